// ==== inc/pmic_regs_pkg.sv ====
// Purpose: Shared constants and carriers for the status/control/flag register bank
// Assumes: Registers are 8 bits wide, reached over an internal byte access port
// Notes: Subaddresses are the device's register numbers
package pmic_regs_pkg;
    localparam logic [7:0] ADDR_STATUS = 8'h05;
    localparam logic [7:0] ADDR_CONTROL = 8'h06;
    localparam logic [7:0] ADDR_FLAGS = 8'h07;

    localparam int STAT_SEAL_BIT = 7;
    localparam int STAT_NVM_BIT = 6;
    localparam int STAT_ADAPTER_BIT = 5;
    localparam int STAT_BUTTON_BIT = 4;
    localparam int STAT_SEQ_LSB = 2;
    localparam int STAT_COIN_LSB = 0;

    localparam int CTRL_MEASURE_BIT = 0;
    localparam int CTRL_PFSHUT_BIT = 1;

    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] READ_IDLE = 8'h00;
    localparam logic [1:0] COIN_RESET = 2'h0;

    // Sequencer state codes as reported to software
    localparam logic [1:0] SEQ_TRANSITION = 2'h0;
    localparam logic [1:0] SEQ_WAIT_POWER_ENABLE = 2'h1;
    localparam logic [1:0] SEQ_ACTIVE = 2'h2;
    localparam logic [1:0] SEQ_SUSPEND = 2'h3;

    // Output rails in flag bit order: conv1..conv4, linreg, out1..out3
    typedef struct packed {
        logic out3;
        logic out2;
        logic out1;
        logic linreg;
        logic conv4;
        logic conv3;
        logic conv2;
        logic conv1;
    } rails_t;

    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [7:0] addr;
        logic [7:0] wdata;
    } regreq_t;
endpackage : pmic_regs_pkg

// ==== src/sync_level.sv ====
// Purpose: Two-stage level sampler with clock enable
// Assumes: Input is a plain level
// Notes: First stage feeds only the second stage
module sync_level (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic din,
    output logic dout
);
    logic stage1_ff;
    logic dout_ff;
    logic nxt_stage1;
    logic nxt_dout;

    always_comb begin
        nxt_stage1 = clkEn ? din : stage1_ff;
        nxt_dout = clkEn ? stage1_ff : dout_ff;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stage1_ff <= 1'b0;
            dout_ff <= 1'b0;
        end else begin
            stage1_ff <= nxt_stage1;
            dout_ff <= nxt_dout;
        end
    end

    assign dout = dout_ff;
endmodule : sync_level

// ==== src/pmic_status_control_regs.sv ====
// Purpose: Status, control and suspend-flag registers of the power manager
// Assumes: Byte register port from the serial management slave; pins asynchronous
// Notes: Read data is registered, valid the cycle after the read request
// What this block does
// - Status bit 7 shows seal broken
// - Status bit 6 shows settings changed
// - Status bit 5 set when adapter pin low
// - Status bit 4 set when button pin low
// - Status bits 3:2 give sequencer state
// - Status bits 1:0 give coin-cell level
// - Writing 1 starts measurement, bit self-clears
// - Shutdown enabled plus power fail: rails off
// - Shutdown disabled: power fail changes nothing
// - Out flags set if kept on in suspend
// - Regulator/converter flags likewise on suspend wake
// - Flags clear after power-up from off, unless a suspend wake comes in the same cycle
module pmic_status_control_regs (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire pmic_regs_pkg::regreq_t regReq,
    output logic [7:0] regRdata,
    output logic regRdValid,
    input wire logic factorySealBroken,
    input wire logic nvmModified,
    input wire logic adapter_detect_pin,
    input wire logic pushbutton_pin,
    input wire logic [1:0] seqState,
    input wire logic [1:0] coinMeasLevel,
    input wire logic coinMeasDone,
    input wire logic powerfail_out_n,
    input wire logic powerUpFromOff,
    input wire logic powerUpFromSuspend,
    input wire pmic_regs_pkg::rails_t railsOnInSuspend,
    output logic coin_cell_measure_start,
    output logic powerfailShutdown
);
    logic adapterSync;
    logic buttonSync;
    logic pfSync_n;

    // Pin samplers; no shared logic looks at their first stage
    sync_level u_syncAdapter (
        .core_clk(core_clk),
        .rst(rst),
        .clkEn(clkEn),
        .din(adapter_detect_pin),
        .dout(adapterSync)
    );
    sync_level u_syncButton (
        .core_clk(core_clk),
        .rst(rst),
        .clkEn(clkEn),
        .din(pushbutton_pin),
        .dout(buttonSync)
    );
    sync_level u_syncPowerFail (
        .core_clk(core_clk),
        .rst(rst),
        .clkEn(clkEn),
        .din(powerfail_out_n),
        .dout(pfSync_n)
    );

    // Control register and measurement trigger
    logic powerfail_shutdown_enable_ff;
    logic measureStart_ff;
    logic shutdown_ff;
    logic nxt_powerfail_shutdown_enable;
    logic nxt_measureStart;
    logic nxt_shutdown;
    logic ctrlWrite;

    always_comb begin
        ctrlWrite = regReq.wrEn && (regReq.addr == pmic_regs_pkg::ADDR_CONTROL);
        nxt_powerfail_shutdown_enable = powerfail_shutdown_enable_ff;
        nxt_measureStart = 1'b0;
        nxt_shutdown = 1'b0;
        if (clkEn) begin
            if (ctrlWrite) begin
                nxt_powerfail_shutdown_enable = regReq.wdata[pmic_regs_pkg::CTRL_PFSHUT_BIT];
                // A written 1 gives a one-cycle start; the stored bit reads 0
                nxt_measureStart = regReq.wdata[pmic_regs_pkg::CTRL_MEASURE_BIT];
            end
            // Shutdown request only when enabled and comparator low
            nxt_shutdown = powerfail_shutdown_enable_ff && !pfSync_n;
        end else begin
            nxt_measureStart = measureStart_ff;
            nxt_shutdown = shutdown_ff;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            powerfail_shutdown_enable_ff <= 1'b0;
            measureStart_ff <= 1'b0;
            shutdown_ff <= 1'b0;
        end else begin
            powerfail_shutdown_enable_ff <= nxt_powerfail_shutdown_enable;
            measureStart_ff <= nxt_measureStart;
            shutdown_ff <= nxt_shutdown;
        end
    end

    assign coin_cell_measure_start = measureStart_ff;
    assign powerfailShutdown = shutdown_ff;

    // Coin-cell level, held from the last completed measurement
    logic [1:0] coin_cell_level_ff;
    logic [1:0] nxt_coin_cell_level;

    always_comb begin
        nxt_coin_cell_level = coin_cell_level_ff;
        if (clkEn && coinMeasDone) begin
            nxt_coin_cell_level = coinMeasLevel;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            coin_cell_level_ff <= pmic_regs_pkg::COIN_RESET;
        end else begin
            coin_cell_level_ff <= nxt_coin_cell_level;
        end
    end

    // Suspend retention flags, updated on each power-up event
    pmic_regs_pkg::rails_t flags_ff;
    pmic_regs_pkg::rails_t nxt_flags;

    always_comb begin
        nxt_flags = flags_ff;
        if (clkEn) begin
            if (powerUpFromSuspend) begin
                // Set for rails kept on, cleared for rails that were off
                nxt_flags = railsOnInSuspend;
            end else if (powerUpFromOff) begin
                nxt_flags = pmic_regs_pkg::FLAGS_RESET;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flags_ff <= pmic_regs_pkg::FLAGS_RESET;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    // Read path; status and flag registers have no write path
    logic [7:0] statusWord;
    logic [7:0] controlWord;
    logic [7:0] rdata_ff;
    logic rdValid_ff;
    logic [7:0] nxt_rdata;
    logic nxt_rdValid;

    always_comb begin
        statusWord = 8'h00;
        statusWord[pmic_regs_pkg::STAT_SEAL_BIT] = factorySealBroken;
        statusWord[pmic_regs_pkg::STAT_NVM_BIT] = nvmModified;
        statusWord[pmic_regs_pkg::STAT_ADAPTER_BIT] = !adapterSync;
        statusWord[pmic_regs_pkg::STAT_BUTTON_BIT] = !buttonSync;
        statusWord[pmic_regs_pkg::STAT_SEQ_LSB +: 2] = seqState;
        statusWord[pmic_regs_pkg::STAT_COIN_LSB +: 2] = coin_cell_level_ff;
        controlWord = pmic_regs_pkg::CONTROL_RESET;
        controlWord[pmic_regs_pkg::CTRL_PFSHUT_BIT] = powerfail_shutdown_enable_ff;
        nxt_rdata = rdata_ff;
        nxt_rdValid = rdValid_ff;
        if (clkEn) begin
            nxt_rdValid = regReq.rdEn;
            if (regReq.rdEn) begin
                unique case (regReq.addr)
                    pmic_regs_pkg::ADDR_STATUS: nxt_rdata = statusWord;
                    pmic_regs_pkg::ADDR_CONTROL: nxt_rdata = controlWord;
                    pmic_regs_pkg::ADDR_FLAGS: nxt_rdata = flags_ff;
                    default: nxt_rdata = pmic_regs_pkg::READ_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_ff <= pmic_regs_pkg::READ_IDLE;
            rdValid_ff <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            rdValid_ff <= nxt_rdValid;
        end
    end

    assign regRdata = rdata_ff;
    assign regRdValid = rdValid_ff;
endmodule : pmic_status_control_regs

// ==== verif/pmic_status_control_regs_properties.sv ====
// Purpose: Timing checks on the register port and power-fail output
// Assumes: clkEn is not dropped in the cycle after a read
// Notes: enFf shadows control bit 1
module pmic_status_control_regs_chk (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire pmic_regs_pkg::regreq_t regReq,
    input wire logic [7:0] regRdata,
    input wire logic regRdValid,
    input wire logic powerfail_out_n,
    input wire logic coin_cell_measure_start,
    input wire logic powerfailShutdown
);
    logic enFf;
    logic nxt_enFf;
    logic ctlWr;
    assign ctlWr = clkEn && regReq.wrEn && regReq.addr == pmic_regs_pkg::ADDR_CONTROL;
    always_comb nxt_enFf = ctlWr ? regReq.wdata[pmic_regs_pkg::CTRL_PFSHUT_BIT] : enFf;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) enFf <= 1'b0;
        else enFf <= nxt_enFf;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence failHeld;
        (!powerfail_out_n && clkEn && enFf && !ctlWr)[*4];
    endsequence
    sequence passHeld;
        (powerfail_out_n && clkEn)[*4];
    endsequence
    a_read_answer: assert property (clkEn && regReq.rdEn |=> regRdValid)
        else $error("read not answered");
    a_read_quiet: assert property (clkEn && !regReq.rdEn |=> !regRdValid)
        else $error("spurious read valid");
    a_start_pulse: assert property (ctlWr && regReq.wdata[0] |=> coin_cell_measure_start)
        else $error("measure start missing");
    a_start_only: assert property (clkEn && !(ctlWr && regReq.wdata[0]) |=> !coin_cell_measure_start)
        else $error("measure start without write");
    a_ctrl_readback: assert property (regRdValid && $past(regReq.addr) == pmic_regs_pkg::ADDR_CONTROL
        |-> regRdata[7:2] == 6'h00 && !regRdata[0])
        else $error("control readback wrong");
    a_shutdown_trip: assert property (failHeld |=> powerfailShutdown)
        else $error("no shutdown on power fail");
    a_shutdown_clear: assert property (passHeld |=> !powerfailShutdown)
        else $error("shutdown without power fail");
    a_shutdown_disabled: assert property ((!enFf && clkEn)[*2] |=> !powerfailShutdown)
        else $error("shutdown while disabled");
endmodule : pmic_status_control_regs_chk

bind pmic_status_control_regs pmic_status_control_regs_chk u_chk (.core_clk, .rst, .clkEn,
    .regReq, .regRdata, .regRdValid, .powerfail_out_n, .coin_cell_measure_start,
    .powerfailShutdown);

// ==== verif/test_pmic_status_control_regs.sv ====
// Purpose: Self-checking bench for the status, control and flag registers
// Assumes: Read data valid one cycle after the request
// Notes: Inputs change at the falling edge
module test_pmic_status_control_regs;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] A_ST = pmic_regs_pkg::ADDR_STATUS;
    localparam logic [7:0] A_CT = pmic_regs_pkg::ADDR_CONTROL;
    localparam logic [7:0] A_FL = pmic_regs_pkg::ADDR_FLAGS;
    logic core_clk = 0, rst = 1, clkEn = 1, seal = 0, nvm = 0, adPin = 1, pbPin = 1;
    logic coinDone = 0, pfPin = 1, upOff = 0, upSus = 0, regRdValid, measStart, pfShut;
    logic [1:0] seq = 0, coin = 0, coinExp = 0;
    logic [7:0] regRdata, flExp, rdSeen;
    logic vldSeen = 0, startSeen = 0;
    pmic_regs_pkg::regreq_t regReq = '0;
    pmic_regs_pkg::rails_t rails = '0;
    int num_errors = 0, compares = 0;
    always #2.5 core_clk = ~core_clk;
    pmic_status_control_regs u_pmic_status_control_regs (.core_clk, .rst, .clkEn, .regReq,
        .regRdata, .regRdValid, .factorySealBroken(seal), .nvmModified(nvm),
        .adapter_detect_pin(adPin), .pushbutton_pin(pbPin), .seqState(seq),
        .coinMeasLevel(coin), .coinMeasDone(coinDone), .powerfail_out_n(pfPin),
        .powerUpFromOff(upOff), .powerUpFromSuspend(upSus), .railsOnInSuspend(rails),
        .coin_cell_measure_start(measStart), .powerfailShutdown(pfShut));
    function automatic logic [7:0] stExp();
        return {seal, nvm, !adPin, !pbPin, seq, coinExp};
    endfunction : stExp
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : cyc
    // Answers are taken before release; one idle cycle keeps requests apart
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
        regReq = '{wrEn: wr, rdEn: !wr, addr: a, wdata: d};
        cyc(1);
        rdSeen = regRdata;
        vldSeen = regRdValid;
        startSeen = measStart;
        regReq = '0;
        cyc(1);
    endtask : acc
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        acc(0, a, 8'h00);
        chk(rdSeen, exp);
        chk({7'h00, vldSeen}, 8'h01);
    endtask : rd
    task automatic print_verdict();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict
    initial begin
        #200us;
        num_errors++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'h64ff));
        cyc(20);
        rst = 0;
        cyc(3);
        rd(A_ST, stExp());
        rd(A_CT, 8'h00);
        rd(A_FL, 8'h00);
        acc(1, A_CT, 8'h01);
        for (int i = 0; i < 8; i++) begin
            {seal, nvm, adPin, pbPin} = 4'($urandom);
            seq = i[1:0];
            coin = ~i[1:0];
            coinExp = coin;
            coinDone = 1;
            cyc(1);
            coinDone = 0;
            cyc(2);
            rd(A_ST, stExp());
        end
        $display("status test done");
        acc(1, A_ST, 8'hff);
        acc(1, A_FL, 8'hff);
        rd(A_ST, stExp());
        rd(A_FL, 8'h00);
        rd(8'h20, 8'h00);
        for (int i = 0; i < 4; i++) begin
            rails = (i == 2) ? 8'h00 : 8'($urandom);
            upSus = i != 1;
            upOff = i[0];
            flExp = upSus ? rails : 8'h00;
            cyc(1);
            {upSus, upOff} = 2'h0;
            rd(A_FL, flExp);
        end
        $display("flag test done");
        acc(1, A_CT, 8'h03);
        chk({7'h00, startSeen}, 8'h01);
        chk({7'h00, measStart}, 8'h00);
        rd(A_CT, 8'h02);
        acc(1, A_CT, 8'h02);
        chk({7'h00, startSeen}, 8'h00);
        pfPin = 0;
        cyc(4);
        chk({7'h00, pfShut}, 8'h01);
        pfPin = 1;
        cyc(4);
        chk({7'h00, pfShut}, 8'h00);
        acc(1, A_CT, 8'h00);
        pfPin = 0;
        cyc(4);
        chk({7'h00, pfShut}, 8'h00);
        pfPin = 1;
        clkEn = 0;
        acc(1, A_CT, 8'h02);
        clkEn = 1;
        rd(A_CT, 8'h00);
        $display("control test done");
        print_verdict();
    end
endmodule : test_pmic_status_control_regs
